// File: logic/pwm_timer_reset_irq_status.v
/*
 * soft reset triggers, interrupt flags, masks and status readback
 * for three pwm timer channels.
 * assumes a simple synchronous register port (write strobe, read
 * strobe, byte address) and one-cycle event pulses from the timers.
 */
// Notes on behaviour
// - write-only reset register at 0x78, bits 0..2 reset timers; zero does nothing.
// - reset bits are one-shot; no write-back of zero needed.
// - soft reset rewinds pattern generator to first pattern and leaves it stopped.
// - soft reset halts all state machines and the counting timer of that channel.
// - soft reset leaves stored pattern words unchanged.
// - soft reset keeps pending flags; host clears them via clear register.
// - raw status at 0x7a: pattern-done bits 5..3, cycle-complete bits 2..0.
// - cycle-complete flag set when active command's pwm cycle finishes.
// - pattern-done flag set when the script task completes.
// - raw bit reads 1 when pending, 0 otherwise; resets to 0.
// - masked status at 0x7b is raw flags gated by per-channel masks.
// - masked bit 1 means the event drives the interrupt output.
// - cycle mask bit 4 of timer config, pattern mask bit 3; 1 masks.
// - clear register at 0x7c clears flags written 1; zero has no effect.
`timescale 1ns/100ps
`include "pwm_irq_map.vh"

module pwm_timer_reset_irq_status #(
	parameter CHANNELS = 3
) (
	// clock and reset
	input  wire                ref_clk,
	input  wire                arst_n,
	// register port
	input  wire                reg_wr,
	input  wire                reg_rd,
	input  wire [7:0]          reg_addr,
	input  wire [7:0]          reg_wdata,
	output reg  [7:0]          reg_rdata_q,
	// events from the timers
	input  wire [CHANNELS-1:0] cycle_done,
	input  wire [CHANNELS-1:0] pattern_done,
	// controls to the timers
	output reg  [CHANNELS-1:0] timer_reset_q,
	output reg  [CHANNELS-1:0] pattern_en_q,
	output reg  [CHANNELS-1:0] pwm_en_q,
	output reg  [CHANNELS-1:0] pwm_off_level_q,
	// interrupt request
	output reg                 irq_q
);

	////////////////////////////////////////////////////////////////////
	reg  [CHANNELS-1:0] cycle_flag_q;
	reg  [CHANNELS-1:0] pattern_flag_q;
	reg  [CHANNELS-1:0] cycle_mask_q;
	reg  [CHANNELS-1:0] pattern_mask_q;
	wire [CHANNELS-1:0] cycle_pend;
	wire [CHANNELS-1:0] pattern_pend;
	wire [7:0]          raw_status;
	wire [7:0]          masked_status;
	wire                wr_reset;
	wire                wr_clear;
	wire [CHANNELS-1:0] reset_req;
	wire [CHANNELS-1:0] cyc_clr;
	wire [CHANNELS-1:0] pat_clr;
	wire [CHANNELS-1:0] timer_cfg_sel;
	wire [CHANNELS-1:0] chan_cfg_sel;
	wire [CHANNELS-1:0] timer_cfg_wr;
	wire [CHANNELS-1:0] chan_cfg_wr;
	wire [CHANNELS-1:0] cycle_flag_d;
	wire [CHANNELS-1:0] pattern_flag_d;
	wire [CHANNELS-1:0] cycle_mask_d;
	wire [CHANNELS-1:0] pattern_mask_d;
	wire [CHANNELS-1:0] pattern_en_d;
	wire [CHANNELS-1:0] pwm_en_d;
	wire [CHANNELS-1:0] pwm_off_level_d;
	reg  [7:0]          cfg_rdata;
	reg  [7:0]          rdata_d;
	integer             k;
	genvar              g;

	assign wr_reset = reg_wr && (reg_addr == `PWM_SOFT_RESET_ADDR);
	assign wr_clear = reg_wr && (reg_addr == `PWM_IRQ_CLEAR_ADDR);
	assign reset_req = wr_reset ? reg_wdata[CHANNELS-1:0] : {CHANNELS{1'b0}};
	assign cyc_clr = wr_clear ? reg_wdata[`CYCLE_FLAG_LSB +: CHANNELS] : {CHANNELS{1'b0}};
	assign pat_clr = wr_clear ? reg_wdata[`PATTERN_FLAG_LSB +: CHANNELS] : {CHANNELS{1'b0}};

	////////////////////////////////////////////////////////////////////
	// per-channel address decode, one comparator pair per timer
	generate
		for (g = 0; g < CHANNELS; g = g + 1) begin : g_dec
			wire [31:0] tc_sum;
			wire [31:0] pc_sum;
			// channel stride keeps every address inside the 8-bit space
			assign tc_sum = `TIMER_CONFIG_BASE + g * `CHAN_STRIDE;
			assign pc_sum = `PWM_CHAN_CONFIG_BASE + g * `CHAN_STRIDE;
			assign timer_cfg_sel[g] = (reg_addr == tc_sum[7:0]);
			assign chan_cfg_sel[g]  = (reg_addr == pc_sum[7:0]);
		end
	endgenerate
	assign timer_cfg_wr = reg_wr ? timer_cfg_sel : {CHANNELS{1'b0}};
	assign chan_cfg_wr  = reg_wr ? chan_cfg_sel : {CHANNELS{1'b0}};

	// set beats clear so an event in the clear cycle is not lost
	// cycle complete sets
	assign cycle_flag_d   = (cycle_flag_q & ~cyc_clr) | cycle_done;
	assign pattern_flag_d = (pattern_flag_q & ~pat_clr) | pattern_done;

	assign cycle_pend   = cycle_flag_q & ~cycle_mask_q;
	assign pattern_pend = pattern_flag_q & ~pattern_mask_q;
	assign raw_status    = {2'b00, pattern_flag_q, cycle_flag_q};
	assign masked_status = {2'b00, pattern_pend, cycle_pend};

	////////////////////////////////////////////////////////////////////
	// event flags: a set in the same cycle as its clear wins
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cycle_flag_q   <= `FLAG_RESET;
			pattern_flag_q <= `FLAG_RESET;
		end else begin
			cycle_flag_q   <= cycle_flag_d;
			pattern_flag_q <= pattern_flag_d;
			// soft reset does not touch flags
		end
	end

	////////////////////////////////////////////////////////////////////
	// channel configuration next values
	// mask bits follow config writes
	assign cycle_mask_d    = (cycle_mask_q & ~timer_cfg_wr)
		| (timer_cfg_wr & {CHANNELS{reg_wdata[`CYCLE_MASK_BIT]}});
	assign pattern_mask_d  = (pattern_mask_q & ~chan_cfg_wr)
		| (chan_cfg_wr & {CHANNELS{reg_wdata[`PATTERN_MASK_BIT]}});
	assign pwm_en_d        = (pwm_en_q & ~chan_cfg_wr)
		| (chan_cfg_wr & {CHANNELS{reg_wdata[`PWM_EN_BIT]}});
	assign pwm_off_level_d = (pwm_off_level_q & ~chan_cfg_wr)
		| (chan_cfg_wr & {CHANNELS{reg_wdata[`PWM_OFF_LEVEL_BIT]}});
	// reset leaves generator stopped
	// the reset wins over an enable written in the same cycle
	assign pattern_en_d    = ((pattern_en_q & ~chan_cfg_wr)
		| (chan_cfg_wr & {CHANNELS{reg_wdata[`PATTERN_EN_BIT]}})) & ~reset_req;

	////////////////////////////////////////////////////////////////////
	// interrupt masks
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cycle_mask_q   <= `MASK_RESET;
			pattern_mask_q <= `MASK_RESET;
		end else begin
			cycle_mask_q   <= cycle_mask_d;
			pattern_mask_q <= pattern_mask_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// level controls to the timers
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pattern_en_q    <= `CTRL_RESET;
			pwm_en_q        <= `CTRL_RESET;
			pwm_off_level_q <= `CTRL_RESET;
		end else begin
			pattern_en_q    <= pattern_en_d;
			pwm_en_q        <= pwm_en_d;
			pwm_off_level_q <= pwm_off_level_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// soft reset pulses
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			timer_reset_q <= `PULSE_RESET;
		end else begin
			timer_reset_q <= reset_req;
		end
	end
	// pattern storage never written
	// the script words live in the timers; this block has no path to them

	////////////////////////////////////////////////////////////////////
	// configuration readback; at most one select is high
	always @* begin
		cfg_rdata = 8'h00;
		for (k = 0; k < CHANNELS; k = k + 1) begin
			if (timer_cfg_sel[k]) begin
				cfg_rdata[`CYCLE_MASK_BIT] = cycle_mask_q[k];
			end
			if (chan_cfg_sel[k]) begin
				cfg_rdata[`PATTERN_MASK_BIT]  = pattern_mask_q[k];
				cfg_rdata[`PATTERN_EN_BIT]    = pattern_en_q[k];
				cfg_rdata[`PWM_EN_BIT]        = pwm_en_q[k];
				cfg_rdata[`PWM_OFF_LEVEL_BIT] = pwm_off_level_q[k];
			end
		end
	end

	// read mux; write-only and unmapped addresses read zero
	always @* begin
		case (reg_addr)
			`PWM_RAW_STATUS_ADDR: begin
				rdata_d = raw_status;
			end
			`PWM_MASKED_STATUS_ADDR: begin
				rdata_d = masked_status;
			end
			default: begin
				rdata_d = cfg_rdata;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// registered read data, held until the next read
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata_q <= `RDATA_RESET;
		end else begin
			if (reg_rd) begin
				reg_rdata_q <= rdata_d;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// interrupt request, one cycle behind the masked status
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_q <= `IRQ_RESET;
		end else begin
			irq_q <= |masked_status;
		end
	end

endmodule // pwm_timer_reset_irq_status

// File: pkg/pwm_irq_map.vh
/*
 * address map, field positions and reset values of the pwm timer
 * soft reset and interrupt status block.
 * assumes an 8-bit register space with 8-bit data.
 */
`ifndef PWM_IRQ_MAP_VH
`define PWM_IRQ_MAP_VH

// channel configuration, one pair per timer, 8 bytes apart
`define TIMER_CONFIG_BASE      8'h60
`define PWM_CHAN_CONFIG_BASE   8'h61
`define CHAN_STRIDE            8'h08
// shared registers
`define PWM_SOFT_RESET_ADDR    8'h78
`define PWM_RAW_STATUS_ADDR    8'h7a
`define PWM_MASKED_STATUS_ADDR 8'h7b
`define PWM_IRQ_CLEAR_ADDR     8'h7c
// field positions
`define CYCLE_MASK_BIT         4
`define PATTERN_MASK_BIT       3
`define PATTERN_EN_BIT         2
`define PWM_EN_BIT             1
`define PWM_OFF_LEVEL_BIT      0
`define PATTERN_FLAG_LSB       3
`define CYCLE_FLAG_LSB         0
// reset values
`define STATUS_RESET           6'h00
`define MASK_RESET             3'h0
`define CHAN_CONFIG_RESET      4'h0
`define FLAG_RESET             3'h0
`define CTRL_RESET             3'h0
`define PULSE_RESET            3'h0
`define RDATA_RESET            8'h00
`define IRQ_RESET              1'b0

`endif

// File: testbench/irq_status_properties.sv
/* assertions on the soft reset and status ports.
   assumes binding onto pwm_timer_reset_irq_status. */
`timescale 1ns/100ps
module irq_status_chk #(parameter CHANNELS = 3) (
	// clock, reset, register port
	input wire ref_clk, arst_n, reg_wr, reg_rd,
	input wire [7:0] reg_addr, reg_wdata, reg_rdata_q,
	// timer side
	input wire [CHANNELS-1:0] cycle_done, pattern_done, timer_reset_q, pattern_en_q,
	input wire irq_q
);
default clocking @(posedge ref_clk); endclocking
default disable iff (!arst_n);
// no write beside the read, so a clear cannot race it
wire rd_raw = reg_rd && reg_addr == 8'h7a && !reg_wr;
sequence s_cyc; cycle_done[0] ##1 !reg_wr ##1 rd_raw; endsequence
sequence s_pat; pattern_done[1] ##1 !reg_wr ##1 rd_raw; endsequence
sequence s_clr;
	reg_wr && reg_addr == 8'h7c && reg_wdata[0] && !cycle_done[0] ##1 !cycle_done[0] ##1 rd_raw;
endsequence
property p_swr; reg_wr && reg_addr == 8'h78 |=> timer_reset_q == $past(reg_wdata[2:0]); endproperty
a_swr: assert property (p_swr) else $error("soft reset bits wrong");
property p_one; !(reg_wr && reg_addr == 8'h78) |=> timer_reset_q == 3'h0; endproperty
a_one: assert property (p_one) else $error("soft reset not one-shot");
property p_stop; (timer_reset_q & pattern_en_q) == 3'h0; endproperty
a_stop: assert property (p_stop) else $error("generator runs in reset");
property p_wo; reg_rd && (reg_addr == 8'h78 || reg_addr == 8'h7c) |=> reg_rdata_q == 8'h00; endproperty
a_wo: assert property (p_wo) else $error("write-only reads nonzero");
property p_irq; reg_rd && reg_addr == 8'h7b |=> irq_q == (reg_rdata_q != 8'h00); endproperty
a_irq: assert property (p_irq) else $error("irq differs from masked");
property p_cyc; s_cyc |=> reg_rdata_q[0]; endproperty
a_cyc: assert property (p_cyc) else $error("cycle flag missing");
property p_pat; s_pat |=> reg_rdata_q[4]; endproperty
a_pat: assert property (p_pat) else $error("pattern flag missing");
property p_clr; s_clr |=> !reg_rdata_q[0]; endproperty
a_clr: assert property (p_clr) else $error("flag not cleared");
property p_keep; !reg_wr ##1 (irq_q && reg_wr && reg_addr == 8'h78) |=> irq_q; endproperty
a_keep: assert property (p_keep) else $error("soft reset dropped irq");
endmodule // irq_status_chk
////////////////////////////////////////////////////////////////////////////////
bind pwm_timer_reset_irq_status irq_status_chk #(.CHANNELS(CHANNELS)) i_chk (.ref_clk, .arst_n,
	.reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata_q, .cycle_done, .pattern_done,
	.timer_reset_q, .pattern_en_q, .irq_q);

// File: testbench/tb.sv
/* register-level bench for soft reset, flags and masks.
   assumes the checker is bound to the design. */
`timescale 1ns/100ps
module tb;
reg ref_clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
reg [2:0] cycle_done = 3'h0, pattern_done = 3'h0;
wire [7:0] reg_rdata_q;
wire [2:0] timer_reset_q, pattern_en_q, pwm_en_q, pwm_off_level_q;
wire irq_q;
int bad_count = 0, comparisons = 0;
always #25 ref_clk = ~ref_clk;
pwm_timer_reset_irq_status i_dut (.ref_clk, .arst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
	.reg_rdata_q, .cycle_done, .pattern_done, .timer_reset_q, .pattern_en_q, .pwm_en_q,
	.pwm_off_level_q, .irq_q);
////////////////////////////////////////////////////////////////////////////////
task chk(input string n, input logic [7:0] e, input logic [7:0] s);
	comparisons++;
	if (s !== e) begin
		bad_count++;
		$display("[FAIL] %s expected %h seen %h", n, e, s);
	end
endtask
// idle edge first, so strobes never toggle twice in one step
task wr(input logic [7:0] a, input logic [7:0] d);
	@(posedge ref_clk);
	#5 reg_wr = 1'b1;
	reg_addr = a;
	reg_wdata = d;
	@(posedge ref_clk);
	#5 reg_wr = 1'b0;
endtask
task rd(input logic [7:0] a, input logic [7:0] e);
	@(posedge ref_clk);
	#5 reg_rd = 1'b1;
	reg_addr = a;
	@(posedge ref_clk);
	#5 reg_rd = 1'b0;
	chk($sformatf("reg %h", a), e, reg_rdata_q);
endtask
task finish_test;
	if (bad_count == 0 && comparisons > 0)
		$display("NO MISMATCHES");
	else
		$display("MISMATCHES SEEN");
	$finish;
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
	repeat (6) @(posedge ref_clk);
	#5 arst_n = 1'b1;
	rd(8'h7a, 8'h00);
	rd(8'h7b, 8'h00);
	rd(8'h78, 8'h00);
	rd(8'h55, 8'h00);
	@(posedge ref_clk);
	#5 cycle_done = 3'h5;
	pattern_done = 3'h2;
	@(posedge ref_clk);
	#5 cycle_done = 3'h0;
	pattern_done = 3'h0;
	rd(8'h7a, 8'h15);
	rd(8'h7b, 8'h15);
	chk("irq", 8'h01, {7'h00, irq_q});
	wr(8'h60, 8'h10);
	wr(8'h69, 8'h08);
	wr(8'h71, 8'h06);
	rd(8'h60, 8'h10);
	rd(8'h7b, 8'h04);
	chk("pwm en", 8'h04, {5'h00, pwm_en_q});
	rd(8'h71, 8'h06);
	wr(8'h61, 8'h05);
	chk("off level", 8'h01, {5'h00, pwm_off_level_q});
	// reserved bits set too, they must not matter
	wr(8'h78, 8'hfc);
	chk("reset", 8'h04, {5'h00, timer_reset_q});
	chk("pattern en", 8'h01, {5'h00, pattern_en_q});
	@(posedge ref_clk);
	#5 chk("reset", 8'h00, {5'h00, timer_reset_q});
	wr(8'h78, 8'h03);
	chk("reset", 8'h03, {5'h00, timer_reset_q});
	chk("pattern en", 8'h00, {5'h00, pattern_en_q});
	rd(8'h71, 8'h02);
	rd(8'h7a, 8'h15);
	wr(8'h7c, 8'hc1);
	rd(8'h7a, 8'h14);
	wr(8'h7c, 8'h3e);
	rd(8'h7a, 8'h00);
	chk("irq", 8'h00, {7'h00, irq_q});
	finish_test;
end
endmodule // tb
